/* File: logic/icd_pkg.sv */
// package for the instruction condition decoder: field positions, encodings, classes
// assumes one core clock; instruction words and flags come from logic on that clock
// Overview of operation
// RQ1: top four bits are a condition on flags; failing instructions are discarded
// RQ2: supplier never uses condition 1111; it is reserved
// RQ3: 0000 passes when zero set; 0001 passes when zero clear
// RQ4: 0010 passes when carry set; 0011 passes when carry clear
// RQ5: 0100 passes when negative set; 0101 passes when negative clear
// RQ6: 0110 passes when overflow set; 0111 passes when overflow clear
// RQ7: 1000 needs carry set, zero clear; 1001 carry clear or zero set
// RQ8: 1010 passes when negative equals overflow; 1011 when they differ
// RQ9: 1100 zero clear and N equals V; 1101 zero set or N differs V
// RQ10: 1110 always passes whatever the flags
// RQ11: exchange branch loads pc from register and state bit from its bit 0
// RQ12: branch with link copies pc to register 14, then loads target
// RQ13: odd undefined encodings like multiply with bit 6 set are not trapped
// RQ14: add with carry adds carry; add and subtract give sum and difference
// RQ15: subtract with carry is a-b-1+c; reverse forms swap operands
// RQ16: bit clear, and, or, xor, move, move inverted write bitwise results
// RQ17: compare and test forms update flags only, no destination write
// RQ18: multiply accumulate adds third register; multiply writes the product
// RQ19: swap loads destination from base word then stores source there
// RQ20: every word is classified from fixed opcode bits before condition gating
`default_nettype none
package icd_pkg;
	localparam int COND_HI = 31;
	localparam int COND_LO = 28;
	localparam int OPC_HI = 24;
	localparam int OPC_LO = 21;
	localparam int SET_FLAGS_BIT = 20;
	localparam int RN_LO = 16;
	localparam int RD_LO = 12;
	localparam int RS_LO = 8;
	localparam int MUL_BIT6 = 6;
	localparam int ACC_BIT = 21;
	localparam int LINK_BIT = 24;
	localparam int OFFS_HI = 23;
	localparam logic [3:0] LINK_REG = 4'hE;
	localparam logic [3:0] COND_RESERVED = 4'hF;
	localparam logic [31:0] BX_PATTERN = 32'h012FFF10;
	localparam logic [31:0] BX_MASK = 32'h0FFFFFF0;
	localparam logic [31:0] MUL_MASK = 32'h0FC000F0;
	localparam logic [31:0] MUL_PATTERN = 32'h00000090;
	localparam logic [31:0] MULL_MASK = 32'h0F8000F0;
	localparam logic [31:0] MULL_PATTERN = 32'h00800090;
	localparam logic [31:0] SWP_MASK = 32'h0FB00FF0;
	localparam logic [31:0] SWP_PATTERN = 32'h01000090;
	localparam logic [31:0] HW_MASK = 32'h0E000090;
	localparam logic [31:0] HW_PATTERN = 32'h00000090;
	localparam logic [31:0] PC_PREFETCH = 32'h00000008;
	localparam logic [31:0] LINK_ADJUST = 32'h00000004;

	typedef enum logic [3:0] {
		COND_EQUAL, COND_NOT_EQUAL, COND_CARRY_SET, COND_CARRY_CLEAR,
		COND_NEGATIVE, COND_POSITIVE, COND_OVERFLOW_SET, COND_OVERFLOW_CLEAR,
		COND_UNSIGNED_HIGHER, COND_UNSIGNED_LOWER_SAME, COND_SIGNED_GE, COND_SIGNED_LT,
		COND_SIGNED_GT, COND_SIGNED_LE, COND_UNCONDITIONAL, COND_RESERVED_CODE
	} icd_cond_t;

	typedef enum logic [3:0] {
		ALU_AND, ALU_EXCLUSIVE_OR, ALU_SUB, ALU_REVERSE_SUB,
		ALU_ADD, ALU_ADD_CARRY, ALU_SUB_CARRY, ALU_REVERSE_SUB_CARRY,
		ALU_TEST_BITS, ALU_TEST_EQUALITY, ALU_COMPARE, ALU_COMPARE_NEGATED,
		ALU_INCLUSIVE_OR, ALU_MOVE, ALU_BIT_CLEAR, ALU_MOVE_INVERTED
	} icd_alu_t;

	typedef enum logic [3:0] {
		CLS_DATA_PROC, CLS_MULTIPLY, CLS_MULTIPLY_LONG, CLS_SWAP, CLS_BRANCH_EXCHANGE,
		CLS_HALFWORD, CLS_SINGLE_XFER, CLS_UNDEFINED, CLS_BLOCK_XFER, CLS_BRANCH,
		CLS_COPROCESSOR, CLS_SOFTWARE_TRAP
	} icd_class_t;
endpackage : icd_pkg
`default_nettype wire

/* File: logic/icd_cond_if.sv */
// interface carrying the condition check between decoder top and its evaluator
// assumes both ends on the core clock; purely combinational contents
`timescale 1ns/1ps
`default_nettype none
interface icd_cond_if;
	import icd_pkg::*;
	logic [3:0] cond;
	logic [3:0] flags_nzcv;
	logic       pass;
	modport top  (output cond, output flags_nzcv, input pass);
	modport eval (input cond, input flags_nzcv, output pass);
endinterface : icd_cond_if
`default_nettype wire

/* File: logic/icd_cond_eval.sv */
// condition evaluator: one instruction condition field against the status flags
// assumes flags arrive as {negative, zero, carry, overflow}
`timescale 1ns/1ps
`default_nettype none
module icd_cond_eval
(
	icd_cond_if.eval cif
);
	import icd_pkg::*;
	logic n_f;
	logic z_f;
	logic c_f;
	logic v_f;
	assign {n_f, z_f, c_f, v_f} = cif.flags_nzcv;

	always_comb
	begin
		unique case (icd_cond_t'(cif.cond))
			COND_EQUAL:               cif.pass = z_f; // RQ3
			COND_NOT_EQUAL:           cif.pass = ~z_f; // RQ3
			COND_CARRY_SET:           cif.pass = c_f; // RQ4
			COND_CARRY_CLEAR:         cif.pass = ~c_f; // RQ4
			COND_NEGATIVE:            cif.pass = n_f; // RQ5
			COND_POSITIVE:            cif.pass = ~n_f; // RQ5
			COND_OVERFLOW_SET:        cif.pass = v_f; // RQ6
			COND_OVERFLOW_CLEAR:      cif.pass = ~v_f; // RQ6
			COND_UNSIGNED_HIGHER:     cif.pass = c_f & ~z_f; // RQ7
			COND_UNSIGNED_LOWER_SAME: cif.pass = ~c_f | z_f; // RQ7
			COND_SIGNED_GE:           cif.pass = (n_f == v_f); // RQ8
			COND_SIGNED_LT:           cif.pass = (n_f != v_f); // RQ8
			COND_SIGNED_GT:           cif.pass = ~z_f & (n_f == v_f); // RQ9
			COND_SIGNED_LE:           cif.pass = z_f | (n_f != v_f); // RQ9
			COND_UNCONDITIONAL:       cif.pass = 1'b1; // RQ10
			// reserved code: the supplier must not send it, so treat as never
			COND_RESERVED_CODE:       cif.pass = 1'b0; // RQ2
		endcase
	end
endmodule // icd_cond_eval
`default_nettype wire

/* File: logic/icd_decode.sv */
// instruction condition decoder top: classify, gate on condition, compute result
// assumes instruction, operands and flags from fetch/register read on the same clock
// results appear one clock after instr_valid_i, all outputs registered
`timescale 1ns/1ps
`default_nettype none
module icd_decode
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        instr_valid_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [31:0] pc_i,
	input  wire logic [3:0]  program_status_flags_i,
	input  wire logic [31:0] first_operand_reg_i,
	input  wire logic [31:0] second_operand_i,
	input  wire logic [31:0] third_operand_i,
	input  wire logic [31:0] mem_read_data_i,
	output logic             done_o,
	output logic             executed_o,
	output icd_pkg::icd_class_t instr_class_o,
	output logic             reg_write_o,
	output logic [3:0]       reg_write_addr_o,
	output logic [31:0]      reg_write_data_o,
	output logic             flags_write_o,
	output logic [3:0]       flags_o,
	output logic             pc_write_o,
	output logic [31:0]      pc_write_data_o,
	output logic             state_bit_write_o,
	output logic             state_bit_o,
	output logic             mem_read_o,
	output logic             mem_write_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_write_data_o,
	output logic             undefined_trap_o
);
	import icd_pkg::*;

	logic rst_sync1_r;
	logic rst_sync2_r;
	logic rst_b;

	// reset asserts at once but leaves on an edge, so no flop sees a half-released reset
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end
		else
		begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end
	assign rst_b = rst_sync2_r;

	icd_cond_if cif ();
	icd_cond_eval u_eval (.cif(cif));
	assign cif.cond = instr_i[COND_HI:COND_LO];
	assign cif.flags_nzcv = program_status_flags_i;

	logic n_f;
	logic z_f;
	logic c_f;
	logic v_f;
	assign {n_f, z_f, c_f, v_f} = program_status_flags_i;

	// classification uses fixed bits only, independent of the condition
	icd_class_t cls;
	always_comb
	begin
		cls = CLS_UNDEFINED;
		if (instr_i[27:24] == 4'hF)
			cls = CLS_SOFTWARE_TRAP; // RQ20
		else if (instr_i[27:26] == 2'b11)
			cls = CLS_COPROCESSOR; // RQ20
		else if (instr_i[27:25] == 3'b101)
			cls = CLS_BRANCH; // RQ20
		else if (instr_i[27:25] == 3'b100)
			cls = CLS_BLOCK_XFER; // RQ20
		else if (instr_i[27:25] == 3'b011 && instr_i[4])
			cls = CLS_UNDEFINED; // RQ20
		else if (instr_i[27:26] == 2'b01)
			cls = CLS_SINGLE_XFER; // RQ20
		else if ((instr_i & BX_MASK) == BX_PATTERN)
			cls = CLS_BRANCH_EXCHANGE; // RQ20
		// bit 6 is excluded from the mask so a set bit 6 still decodes as multiply
		else if ((instr_i & MUL_MASK & ~(32'h1 << MUL_BIT6)) == MUL_PATTERN)
			cls = CLS_MULTIPLY; // RQ13
		else if ((instr_i & MULL_MASK) == MULL_PATTERN)
			cls = CLS_MULTIPLY_LONG; // RQ20
		else if ((instr_i & SWP_MASK) == SWP_PATTERN)
			cls = CLS_SWAP; // RQ20
		else if ((instr_i & HW_MASK) == HW_PATTERN)
			cls = CLS_HALFWORD; // RQ20
		else
			cls = CLS_DATA_PROC; // RQ20
	end

	// ALU: 33-bit sums give the carry out of bit 31
	icd_alu_t   alu_op;
	logic [32:0] alu_sum;
	logic [31:0] alu_res;
	logic        alu_arith;
	logic        alu_sub;
	logic        alu_test;
	logic [31:0] opa;
	logic [31:0] opb;
	assign alu_op = icd_alu_t'(instr_i[OPC_HI:OPC_LO]);
	assign opa = first_operand_reg_i;
	assign opb = second_operand_i;

	always_comb
	begin
		alu_sum = 33'h0;
		alu_res = 32'h0;
		alu_arith = 1'b0;
		alu_sub = 1'b0;
		alu_test = 1'b0;
		unique case (alu_op)
			ALU_AND:            alu_res = opa & opb; // RQ16
			ALU_EXCLUSIVE_OR:   alu_res = opa ^ opb; // RQ16
			ALU_SUB:
			begin
				alu_sum = {1'b0, opa} + {1'b0, ~opb} + 33'h1; // RQ14
				alu_arith = 1'b1;
				alu_sub = 1'b1;
			end
			ALU_REVERSE_SUB:
			begin
				alu_sum = {1'b0, opb} + {1'b0, ~opa} + 33'h1; // RQ15
				alu_arith = 1'b1;
				alu_sub = 1'b1;
			end
			ALU_ADD:
			begin
				alu_sum = {1'b0, opa} + {1'b0, opb}; // RQ14
				alu_arith = 1'b1;
			end
			ALU_ADD_CARRY:
			begin
				alu_sum = {1'b0, opa} + {1'b0, opb} + {32'h0, c_f}; // RQ14
				alu_arith = 1'b1;
			end
			ALU_SUB_CARRY:
			begin
				// a - b - 1 + c equals a + ~b + c
				alu_sum = {1'b0, opa} + {1'b0, ~opb} + {32'h0, c_f}; // RQ15
				alu_arith = 1'b1;
				alu_sub = 1'b1;
			end
			ALU_REVERSE_SUB_CARRY:
			begin
				alu_sum = {1'b0, opb} + {1'b0, ~opa} + {32'h0, c_f}; // RQ15
				alu_arith = 1'b1;
				alu_sub = 1'b1;
			end
			ALU_TEST_BITS:
			begin
				alu_res = opa & opb; // RQ17
				alu_test = 1'b1;
			end
			ALU_TEST_EQUALITY:
			begin
				alu_res = opa ^ opb; // RQ17
				alu_test = 1'b1;
			end
			ALU_COMPARE:
			begin
				alu_sum = {1'b0, opa} + {1'b0, ~opb} + 33'h1; // RQ17
				alu_arith = 1'b1;
				alu_sub = 1'b1;
				alu_test = 1'b1;
			end
			ALU_COMPARE_NEGATED:
			begin
				alu_sum = {1'b0, opa} + {1'b0, opb}; // RQ17
				alu_arith = 1'b1;
				alu_test = 1'b1;
			end
			ALU_INCLUSIVE_OR:   alu_res = opa | opb; // RQ16
			ALU_MOVE:           alu_res = opb; // RQ16
			ALU_BIT_CLEAR:      alu_res = opa & ~opb; // RQ16
			ALU_MOVE_INVERTED:  alu_res = ~opb; // RQ16
		endcase
		if (alu_arith)
			alu_res = alu_sum[31:0];
	end

	// flags: arithmetic sets V from sign overflow, logical keeps V and C
	// no shifter sits in front of this block, so logical ops have no carry of their own
	logic [3:0]  alu_flags;
	logic        ovf;
	logic [31:0] eff_b;
	always_comb
	begin
		eff_b = alu_sub ? ~opb : opb;
		if (alu_op == ALU_REVERSE_SUB || alu_op == ALU_REVERSE_SUB_CARRY)
			ovf = (opb[31] == ~opa[31]) && (alu_res[31] != opb[31]);
		else
			ovf = (opa[31] == eff_b[31]) && (alu_res[31] != opa[31]);
		if (alu_arith)
			alu_flags = {alu_res[31], alu_res == 32'h0, alu_sum[32], ovf};
		else
			alu_flags = {alu_res[31], alu_res == 32'h0, c_f, v_f};
	end

	// only the low word of a product is kept; long multiply is classified, not executed
	logic [31:0] product;
	logic [31:0] mul_res;
	assign product = opa * opb;
	// for multiply: opa is Rm, opb is Rs, third is accumulator
	assign mul_res = instr_i[ACC_BIT] ? product + third_operand_i : product; // RQ18

	// offset counts words from the prefetch address, eight bytes past the instruction
	logic [31:0] branch_target;
	assign branch_target = pc_i + PC_PREFETCH
		+ {{6{instr_i[OFFS_HI]}}, instr_i[OFFS_HI:0], 2'b00};

	// a failed condition still reports done so the fetch side can count every word
	logic go;
	assign go = instr_valid_i & cif.pass; // RQ1

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			done_o <= 1'b0;
			executed_o <= 1'b0;
			instr_class_o <= CLS_DATA_PROC;
			undefined_trap_o <= 1'b0;
		end
		else
		begin
			done_o <= instr_valid_i;
			executed_o <= go; // RQ1
			instr_class_o <= cls; // RQ20
			undefined_trap_o <= go && cls == CLS_UNDEFINED; // RQ13
		end
	end

	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_write_o <= 1'b0;
			reg_write_addr_o <= 4'h0;
			reg_write_data_o <= 32'h0;
			flags_write_o <= 1'b0;
			flags_o <= 4'h0;
		end
		else
		begin
			reg_write_o <= 1'b0;
			flags_write_o <= 1'b0;
			if (go)
			begin
				unique case (cls)
					CLS_DATA_PROC:
					begin
						reg_write_o <= ~alu_test; // RQ17
						reg_write_addr_o <= instr_i[RD_LO +: 4];
						reg_write_data_o <= alu_res; // RQ14
						flags_write_o <= instr_i[SET_FLAGS_BIT] | alu_test; // RQ17
						flags_o <= alu_flags;
					end
					CLS_MULTIPLY:
					begin
						reg_write_o <= 1'b1; // RQ18
						reg_write_addr_o <= instr_i[RN_LO +: 4];
						reg_write_data_o <= mul_res; // RQ18
						flags_write_o <= instr_i[SET_FLAGS_BIT];
						flags_o <= {mul_res[31], mul_res == 32'h0, c_f, v_f};
					end
					CLS_SWAP:
					begin
						reg_write_o <= 1'b1; // RQ19
						reg_write_addr_o <= instr_i[RD_LO +: 4];
						reg_write_data_o <= mem_read_data_i; // RQ19
					end
					CLS_BRANCH:
					begin
						reg_write_o <= instr_i[LINK_BIT]; // RQ12
						reg_write_addr_o <= LINK_REG; // RQ12
						reg_write_data_o <= (pc_i + LINK_ADJUST) & ~32'h3; // RQ12
					end
					default:
					begin
						reg_write_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// control flow and memory side effects
	// address and store data hold after the strobe for a memory that latches late
	always_ff @(posedge clk_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pc_write_o <= 1'b0;
			pc_write_data_o <= 32'h0;
			state_bit_write_o <= 1'b0;
			state_bit_o <= 1'b0;
			mem_read_o <= 1'b0;
			mem_write_o <= 1'b0;
			mem_addr_o <= 32'h0;
			mem_write_data_o <= 32'h0;
		end
		else
		begin
			pc_write_o <= 1'b0;
			state_bit_write_o <= 1'b0;
			mem_read_o <= 1'b0;
			mem_write_o <= 1'b0;
			if (go && cls == CLS_BRANCH_EXCHANGE)
			begin
				pc_write_o <= 1'b1; // RQ11
				pc_write_data_o <= first_operand_reg_i; // RQ11
				state_bit_write_o <= 1'b1; // RQ11
				state_bit_o <= first_operand_reg_i[0]; // RQ11
			end
			else if (go && cls == CLS_BRANCH)
			begin
				pc_write_o <= 1'b1; // RQ12
				pc_write_data_o <= branch_target;
			end
			// swap: read data is sampled with the same word; store of source follows
			if (go && cls == CLS_SWAP)
			begin
				mem_read_o <= 1'b1; // RQ19
				mem_write_o <= 1'b1; // RQ19
				mem_addr_o <= first_operand_reg_i; // RQ19
				mem_write_data_o <= second_operand_i; // RQ19
			end
		end
	end
endmodule // icd_decode
`default_nettype wire

/* File: verification/icd_mem_model.sv */
// swap memory beside the decoder: small word array on the core clock
// assumes the bench offers the base address together with each instruction
`timescale 1ns/1ps
`default_nettype none
module icd_mem_model
(
	input  wire logic        clk_i,
	input  wire logic [31:0] base_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] wr_addr_i,
	input  wire logic [31:0] wr_data_i,
	output logic      [31:0] rd_o
);
	logic [31:0] mem_r [16];
	initial
	begin
		for (int i = 0; i < 16; i++)
			mem_r[i] = 32'hA5000000 + 32'(i);
	end
	// byte lane bits dropped: the decoder only swaps whole words
	assign rd_o = mem_r[base_i[5:2]];
	always @(posedge clk_i)
	begin
		if (wr_i)
			mem_r[wr_addr_i[5:2]] <= wr_data_i;
	end
endmodule // icd_mem_model
`default_nettype wire

/* File: verification/icd_decode_chk.sv */
// timing checks on the decoder top ports
// assumes no word is offered before the third edge after reset release
`timescale 1ns/1ps
`default_nettype none
module icd_decode_chk
	import icd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [3:0]  program_status_flags_i,
	input wire logic [31:0] first_operand_reg_i,
	input wire logic        done_o,
	input wire logic        executed_o,
	input wire logic        reg_write_o,
	input wire logic [3:0]  reg_write_addr_o,
	input wire logic        flags_write_o,
	input wire logic        pc_write_o,
	input wire logic [31:0] pc_write_data_o,
	input wire logic        state_bit_o,
	input wire logic        mem_read_o,
	input wire logic        mem_write_o,
	input wire logic        undefined_trap_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic [3:0] f  = program_status_flags_i;
	wire logic       go = instr_valid_i && instr_i[31:28] == 4'hE;
	wire logic       zr = instr_i[28] ^ f[2];
	wire logic       ng = instr_i[28] ^ f[3];
	wire logic       ge = instr_i[28] ^ (f[3] == f[0]);
	chk_done_follows: assert property (instr_valid_i |=> done_o)
		else $error("done missing");
	chk_idle_quiet: assert property (!instr_valid_i |=> !done_o && !executed_o)
		else $error("strobe without word");
	chk_effects_gated: assert property (!executed_o |-> !(reg_write_o || pc_write_o || mem_write_o))
		else $error("effect of skipped word");
	chk_zero_cond: assert property (instr_valid_i && instr_i[31:29] == 3'h0 |=> executed_o == $past(zr))
		else $error("zero condition wrong");
	chk_sign_cond: assert property (instr_valid_i && instr_i[31:29] == 3'h2 |=> executed_o == $past(ng))
		else $error("negative condition wrong");
	chk_ge_cond: assert property (instr_valid_i && instr_i[31:29] == 3'h5 |=> executed_o == $past(ge))
		else $error("signed condition wrong");
	chk_always_runs: assert property (go |-> ##1 executed_o)
		else $error("always condition failed");
	chk_exchange_load: assert property (go && (instr_i & BX_MASK) == BX_PATTERN |=>
		pc_write_o && pc_write_data_o == $past(first_operand_reg_i) && state_bit_o == $past(first_operand_reg_i[0]))
		else $error("exchange branch wrong");
	chk_link_write: assert property (go && instr_i[27:24] == 4'hB |=> reg_write_o && reg_write_addr_o == LINK_REG)
		else $error("link register not written");
	chk_test_only: assert property (go && instr_i[27:23] == 5'h06 |=> flags_write_o && !reg_write_o)
		else $error("compare wrote a register");
	chk_swap_both: assert property (go && (instr_i & SWP_MASK) == SWP_PATTERN |=> mem_read_o && mem_write_o)
		else $error("swap access missing");
	chk_mul_no_trap: assert property (go && (instr_i & 32'h0FC000B0) == 32'h00000090 |=> !undefined_trap_o)
		else $error("multiply trapped");
endmodule // icd_decode_chk
bind icd_decode icd_decode_chk chk_u (.clk_i, .rst_b_i, .instr_valid_i, .instr_i, .program_status_flags_i,
	.first_operand_reg_i, .done_o, .executed_o, .reg_write_o, .reg_write_addr_o, .flags_write_o, .pc_write_o,
	.pc_write_data_o, .state_bit_o, .mem_read_o, .mem_write_o, .undefined_trap_o);
`default_nettype wire

/* File: verification/icd_decode_tb_top.sv */
// bench for the decoder: condition table, operations, multiply, swap, branches, classes
// assumes the checker binds itself and the swap memory model answers the memory port
`timescale 1ns/1ps
`default_nettype none
module icd_decode_tb_top;
	import icd_pkg::*;
	logic        clk_i = 1'b0, rst_b_i = 1'b0, instr_valid_i = 1'b0;
	logic [31:0] instr_i = '0, pc_i = '0, first_operand_reg_i = '0, second_operand_i = '0, third_operand_i = '0;
	logic [3:0]  program_status_flags_i = '0, reg_write_addr_o, flags_o;
	logic        done_o, executed_o, reg_write_o, flags_write_o, pc_write_o, state_bit_write_o, state_bit_o;
	logic        mem_read_o, mem_write_o, undefined_trap_o;
	logic [31:0] reg_write_data_o, pc_write_data_o, mem_addr_o, mem_write_data_o;
	wire logic [31:0] mem_read_data_i;
	icd_class_t  instr_class_o;
	int          fails = 0, n_checks = 0;
	always #25 clk_i = ~clk_i;
	icd_decode dut_u (.clk_i, .rst_b_i, .instr_valid_i, .instr_i, .pc_i, .program_status_flags_i,
		.first_operand_reg_i, .second_operand_i, .third_operand_i, .mem_read_data_i, .done_o, .executed_o,
		.instr_class_o, .reg_write_o, .reg_write_addr_o, .reg_write_data_o, .flags_write_o, .flags_o,
		.pc_write_o, .pc_write_data_o, .state_bit_write_o, .state_bit_o, .mem_read_o, .mem_write_o,
		.mem_addr_o, .mem_write_data_o, .undefined_trap_o);
	icd_mem_model mem_u (.clk_i, .base_i(first_operand_reg_i), .wr_i(mem_write_o), .wr_addr_i(mem_addr_o),
		.wr_data_i(mem_write_data_o), .rd_o(mem_read_data_i));
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// one word per call with an idle edge after it, results read mid-cycle
	task automatic run(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		@(negedge clk_i);
		instr_i = w;
		first_operand_reg_i = a;
		second_operand_i = b;
		third_operand_i = c;
		instr_valid_i = 1'b1;
		@(negedge clk_i);
		instr_valid_i = 1'b0;
		ck("done", 1'b1, done_o);
	endtask
	function automatic logic pass_f(input logic [3:0] c, input logic [3:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[2];
			3'h1: r = f[1];
			3'h2: r = f[3];
			3'h3: r = f[0];
			3'h4: r = f[1] && !f[2];
			3'h5: r = f[3] == f[0];
			3'h6: r = !f[2] && f[3] == f[0];
			default: r = 1'b1;
		endcase
		return r ^ c[0];
	endfunction
	task automatic t_cond();
		for (int c = 0; c < 15; c++)
			for (int f = 0; f < 16; f++)
			begin
				program_status_flags_i = 4'(f);
				run({4'(c), 28'h3A0205A}, 32'h0, 32'h5A, 32'h0);
				ck("executed", pass_f(4'(c), 4'(f)), executed_o);
				ck("write", pass_f(4'(c), 4'(f)), reg_write_o);
			end
	endtask
	task automatic t_alu();
		logic [31:0] a, b, r, cy;
		a = 32'h80000005;
		b = 32'h00000007;
		for (int k = 0; k < 2; k++)
			for (int op = 0; op < 16; op++)
			begin
				cy = 32'(k);
				program_status_flags_i = {2'h0, cy[0], 1'b0};
				case (op)
					0, 8: r = a & b;
					1, 9: r = a ^ b;
					2, 10: r = a - b;
					3: r = b - a;
					4, 11: r = a + b;
					5: r = a + b + cy;
					6: r = a - b - 32'h1 + cy;
					7: r = b - a - 32'h1 + cy;
					12: r = a | b;
					13: r = b;
					14: r = a & ~b;
					default: r = ~b;
				endcase
				run(32'hE2101000 | (32'(op) << 21), a, b, 32'h0);
				ck("write", op < 8 || op > 11, reg_write_o);
				if (op < 8 || op > 11)
					ck("result", r, reg_write_data_o);
				else
					ck("nz", {r[31], r == 32'h0}, flags_o[3:2]);
				if (op > 7 && op < 12)
					ck("cv", op == 10 ? 2'h3 : op == 11 ? 2'h0 : {cy[0], 1'b0}, flags_o[1:0]);
				ck("flagwr", 1'b1, flags_write_o);
				ck("class", CLS_DATA_PROC, instr_class_o);
			end
	endtask
	task automatic t_mul();
		logic [31:0] w [3] = '{32'hE0030291, 32'hE0230291, 32'hE00302D1};
		for (int i = 0; i < 3; i++)
		begin
			run(w[i], 32'h00010003, 32'h00000021, 32'h00000100);
			ck("product", i == 1 ? 32'h00210163 : 32'h00210063, reg_write_data_o);
			ck("dest", 4'h3, reg_write_addr_o);
			ck("trap", 1'b0, undefined_trap_o);
			ck("class", CLS_MULTIPLY, instr_class_o);
		end
	endtask
	task automatic t_swap();
		for (int i = 0; i < 2; i++)
		begin
			run(32'hE1045096, 32'h00000014, 32'hC0DE0000 + 32'(i), 32'h0);
			ck("load", i ? 32'hC0DE0000 : 32'hA5000005, reg_write_data_o);
			ck("addr", 32'h00000014, mem_addr_o);
			ck("store", 32'hC0DE0000 + 32'(i), mem_write_data_o);
			ck("access", 2'h3, {mem_read_o, mem_write_o});
			ck("class", CLS_SWAP, instr_class_o);
		end
	endtask
	task automatic t_branch();
		pc_i = 32'h00001000;
		program_status_flags_i = 4'h0;
		run(32'h0B000010, 32'h0, 32'h0, 32'h0);
		ck("skip", 3'h0, {reg_write_o, pc_write_o, executed_o});
		run(32'hEB000010, 32'h0, 32'h0, 32'h0);
		ck("link", {1'b1, LINK_REG}, {reg_write_o, reg_write_addr_o});
		ck("ret", 32'h00001004, reg_write_data_o);
		ck("target", 32'h00001048, pc_write_data_o);
		ck("jump", 1'b1, pc_write_o);
		ck("class", CLS_BRANCH, instr_class_o);
		for (int i = 0; i < 2; i++)
		begin
			run(32'hE12FFF13, 32'h00002000 + 32'(i), 32'h0, 32'h0);
			ck("pc", 32'h00002000 + 32'(i), pc_write_data_o);
			ck("pcw", 1'b1, pc_write_o);
			ck("state", {1'b1, i[0]}, {state_bit_write_o, state_bit_o});
			ck("class", CLS_BRANCH_EXCHANGE, instr_class_o);
		end
	endtask
	task automatic t_class();
		logic [31:0] w [6] = '{32'hE5900000, 32'hE8900001, 32'hEE000000, 32'hEF000000, 32'hE1D000B0, 32'hE6000010};
		icd_class_t  k [6] = '{CLS_SINGLE_XFER, CLS_BLOCK_XFER, CLS_COPROCESSOR, CLS_SOFTWARE_TRAP,
			CLS_HALFWORD, CLS_UNDEFINED};
		for (int i = 0; i < 6; i++)
		begin
			run(w[i], 32'h0, 32'h0, 32'h0);
			ck("class", k[i], instr_class_o);
			ck("trap", k[i] == CLS_UNDEFINED, undefined_trap_o);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge clk_i);
		t_cond();
		t_alu();
		t_mul();
		t_swap();
		t_branch();
		t_class();
		complete_run();
	end
	// about 590 cycles expected; allow nearly seven times that
	initial
	begin
		#200000;
		fails++;
		complete_run();
	end
endmodule // icd_decode_tb_top
`default_nettype wire
